/* common/rlr_pkg.sv */
package rlr_pkg;

	// Value format: signed tenths of a percent, FB fraction bits inside the accumulator
	localparam int VW = 16;
	localparam int FB = 16;
	localparam int AW = VW + FB;
	localparam int RW = 13;
	localparam int QW = 26;
	localparam int DW = 20;

	// Values after reset
	localparam logic [RW-1:0]        RAMP_RST   = 13'h0064;
	localparam logic signed [VW-1:0] PRESET_RST = 16'sh0000;
	localparam logic signed [VW-1:0] UPPER_RST  = 16'sh03E8;
	localparam logic signed [VW-1:0] LOWER_RST  = 16'shFC18;

	// Ranges: +/-500.0 % and 600.0 s
	localparam logic signed [VW-1:0] VAL_LIM  = 16'sh1388;
	localparam logic [RW-1:0]        RAMP_MAX = 13'h1770;

	// Full swing 0 % to 100.0 % with fraction bits, and the jump used for a zero ramp time
	localparam logic [QW-1:0] FULL_SCALE = 26'h3E80000;
	localparam logic [AW-1:0] STEP_MAX   = 32'h27100000;

	// Update tick timing
	localparam int CLK_MHZ      = 25;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;
	localparam int TICKS_PER_DS = 100000 / TICK_TIME_US;

	// Register byte addresses
	localparam logic [7:0] A_RAMP   = 8'h00;
	localparam logic [7:0] A_PRESET = 8'h04;
	localparam logic [7:0] A_UPPER  = 8'h08;
	localparam logic [7:0] A_LOWER  = 8'h0C;
	localparam logic [7:0] A_OUTPUT = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;

	// Control input bit positions
	localparam int CTL_N     = 3;
	localparam int CTL_RAISE = 0;
	localparam int CTL_LOWER = 1;
	localparam int CTL_PRESET = 2;

	typedef enum logic [2:0]
	{
		ST_RESTORE = 3'b001,
		ST_CALC    = 3'b010,
		ST_RUN     = 3'b100
	} rlr_state_t;

endpackage

/* dv/rlr_pins_model.sv */
`timescale 1ns/1ps
module rlr_pins_model
	import rlr_pkg::*;
(
	// Clock
	input  wire logic                 clk_i,
	// Pins toward the block
	output logic                      raise_o,
	output logic                      lower_o,
	output logic                      preset_load_o,
	// Retention store
	input  wire logic signed [VW-1:0] store_i,
	input  wire logic                 store_stb_i,
	output logic signed [VW-1:0]      value_o,
	output logic                      valid_o
);
	// Pins start released; an empty store shows junk, so only valid_o may be trusted
	initial
	begin
		raise_o = 1'b0;
		lower_o = 1'b0;
		preset_load_o = 1'b0;
		value_o = 16'sh5A5A;
		valid_o = 1'b0;
	end

	// Store keeps the last saved word and is never cleared by the block reset
	always @(posedge clk_i)
	begin
		if (store_stb_i)
		begin
			value_o <= store_i;
			valid_o <= 1'b1;
		end
	end

	// Contacts change just after an edge, like a switch seen by the block
	task automatic set_pins(input logic r, input logic l, input logic p);
		@(posedge clk_i);
		raise_o <= r;
		lower_o <= l;
		preset_load_o <= p;
	endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
	import rlr_pkg::*;
	localparam int TL = 50;
	logic                 clk_i, srst_i, wr_i, rd_i;
	logic [7:0]           addr_i;
	logic [31:0]          wdata_i, rdata_o, rv;
	logic                 raise, lower, preset_load, nv_valid, nv_store_stb;
	logic signed [VW-1:0] nv_value, nv_store, out_value_o, hv;
	int                   failures, comparisons;

	// Clock at 25 MHz
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	rlr_ramp #(.TICK_LEN(TL)) u_rlr_ramp (.clk_i(clk_i), .srst_i(srst_i), .raise_i(raise),
		.lower_i(lower), .preset_load_i(preset_load), .nv_value_i(nv_value),
		.nv_valid_i(nv_valid), .nv_store_o(nv_store), .nv_store_stb_o(nv_store_stb),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.out_value_o(out_value_o));

	rlr_pins_model u_rlr_pins_model (.clk_i(clk_i), .raise_o(raise), .lower_o(lower),
		.preset_load_o(preset_load), .store_i(nv_store), .store_stb_i(nv_store_stb),
		.value_o(nv_value), .valid_o(nv_valid));

	// Verdict and end of run
	task automatic wrap_up();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Shared comparison
	task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp,
		input string msg);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %s seen %0d expected %0d", $time, msg, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rv = rdata_o;
	endtask

	// Bounded wait for an output value; running out ends the run
	task automatic wait_val(input logic signed [VW-1:0] v, input int n);
		for (int k = 0; k < n && out_value_o !== v; k++)
		begin
			@(posedge clk_i);
			#1;
		end
		if (out_value_o !== v)
		begin
			failures++;
			$display("wrong value at %0t: output never reached %0d", $time, v);
			wrap_up();
		end
	endtask

	// Movement over ten ticks, measured from just after a step
	task automatic rate(input logic signed [31:0] d);
		logic signed [VW-1:0] v0;
		v0 = out_value_o;
		wait_val(v0 + d / 10, 3 * TL);
		v0 = out_value_o;
		repeat (10 * TL) @(posedge clk_i);
		#1;
		check(out_value_o - v0, d, "ten-tick movement");
	endtask

	// Values after reset and the unmapped place
	task automatic t_reset_values();
		rd(A_RAMP);   check(rv, 100, "ramp reset");
		rd(A_PRESET); check(rv, 0, "preset reset");
		rd(A_UPPER);  check(rv, 1000, "upper reset");
		rd(A_LOWER);  check(rv, 32'hFFFFFC18, "lower reset");
		rd(A_OUTPUT); check(rv, 0, "output reset");
		rd(8'h40);    check(rv, 0, "unmapped read");
		$display("test reset_values done");
	endtask

	// Range clamp, read-only output, then a short ramp for the tests before the restart
	task automatic t_config();
		wr(A_RAMP, 32'h00001B58);
		rd(A_RAMP); check(rv, 6000, "ramp clamp");
		wr(A_OUTPUT, 32'h0000007B);
		rd(A_OUTPUT); check(rv, 0, "output write ignored");
		wr(A_RAMP, 32'h00000001);
		wr(A_UPPER, 32'h0000012C);
		wr(A_LOWER, 32'hFFFFFF38);
		repeat (40) @(posedge clk_i);
		rd(A_STATUS); check(rv, 32'h00000040, "status run");
		$display("test config done");
	endtask

	// Raise, both kinds of hold, then run into the upper limit
	task automatic t_raise();
		u_rlr_pins_model.set_pins(1'b1, 1'b0, 1'b0);
		rate(100);
		u_rlr_pins_model.set_pins(1'b0, 1'b0, 1'b0);
		repeat (10) @(posedge clk_i);
		#1;
		hv = out_value_o;
		repeat (5 * TL) @(posedge clk_i);
		#1;
		check(out_value_o, hv, "hold neither");
		u_rlr_pins_model.set_pins(1'b1, 1'b1, 1'b0);
		repeat (5 * TL) @(posedge clk_i);
		#1;
		check(out_value_o, hv, "hold both");
		u_rlr_pins_model.set_pins(1'b1, 1'b0, 1'b0);
		wait_val(300, 40 * TL);
		repeat (5 * TL) @(posedge clk_i);
		#1;
		check(out_value_o, 300, "stop at upper");
		rd(A_OUTPUT); check(rv, 300, "monitor read");
		$display("test raise done");
	endtask

	// Lower at the same rate down to the lower limit
	task automatic t_lower();
		u_rlr_pins_model.set_pins(1'b0, 1'b1, 1'b0);
		rate(-100);
		wait_val(-200, 60 * TL);
		repeat (5 * TL) @(posedge clk_i);
		#1;
		check(out_value_o, -200, "stop at lower");
		$display("test lower done");
	endtask

	// Preset beyond both limits, then pull-back after release
	task automatic t_pull();
		wr(A_PRESET, 32'h000001F4);
		u_rlr_pins_model.set_pins(1'b1, 1'b1, 1'b1);
		wait_val(500, 10);
		u_rlr_pins_model.set_pins(1'b0, 1'b0, 1'b0);
		rate(-100);
		wait_val(300, 20 * TL);
		wr(A_PRESET, 32'hFFFFFE70);
		u_rlr_pins_model.set_pins(1'b0, 1'b1, 1'b1);
		wait_val(-400, 10);
		u_rlr_pins_model.set_pins(1'b0, 1'b0, 1'b0);
		rate(100);
		wait_val(-200, 30 * TL);
		$display("test pull done");
	endtask

	// Upper not above lower forces the upper value, even over the preset pin
	task automatic t_cross();
		wr(A_UPPER, 32'hFFFFFED4);
		wait_val(-300, 10);
		u_rlr_pins_model.set_pins(1'b0, 1'b0, 1'b1);
		repeat (20) @(posedge clk_i);
		#1;
		check(out_value_o, -300, "crossed limits");
		u_rlr_pins_model.set_pins(1'b0, 1'b0, 1'b0);
		wr(A_UPPER, 32'h0000012C);
		wait_val(-200, 30 * TL);
		$display("test cross done");
	endtask

	// Output survives a restart through the retention store, then a zero ramp time jumps
	task automatic t_retain();
		repeat (4) @(posedge clk_i);
		check(nv_valid, 1'b1, "store filled");
		check(nv_value, -200, "stored value");
		srst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		wait_val(-200, 60);
		wr(A_RAMP, 32'h00000000);
		repeat (40) @(posedge clk_i);
		u_rlr_pins_model.set_pins(1'b1, 1'b0, 1'b0);
		wait_val(1000, 2 * TL);
		$display("test retain done");
	endtask

	// Main sequence
	initial
	begin
		failures = 0;
		comparisons = 0;
		srst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h00000000;
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		t_reset_values();
		repeat (60) @(posedge clk_i);
		t_config();
		t_raise();
		t_lower();
		t_pull();
		t_cross();
		t_retain();
		wrap_up();
	end
endmodule

/* logic/rlr_div.sv */
`timescale 1ns/1ps
module rlr_div
	import rlr_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          srst_i,
	// Request
	input  wire logic          start_i,
	input  wire logic [QW-1:0] dividend_i,
	input  wire logic [DW-1:0] divisor_i,
	// Answer
	output logic               busy_o,
	output logic               done_o,
	output logic [QW-1:0]      quot_o
);

	logic          busy_reg, busy_next;
	logic          done_reg, done_next;
	logic [4:0]    cnt_reg, cnt_next;
	logic [DW:0]   rem_reg, rem_next;
	logic [QW-1:0] quo_reg, quo_next;
	logic [DW-1:0] div_reg, div_next;
	logic [DW:0]   trial;

	// Restoring division, one quotient bit per clock; a new start restarts it
	always_comb
	begin
		busy_next = busy_reg;
		done_next = 1'b0;
		cnt_next  = cnt_reg;
		rem_next  = rem_reg;
		quo_next  = quo_reg;
		div_next  = div_reg;
		trial     = {rem_reg[DW-1:0], quo_reg[QW-1]};
		if (start_i)
		begin
			busy_next = 1'b1;
			cnt_next  = 5'(QW - 1);
			rem_next  = '0;
			quo_next  = dividend_i;
			div_next  = divisor_i;
		end
		else if (busy_reg)
		begin
			quo_next = {quo_reg[QW-2:0], 1'b0};
			if (trial >= {1'b0, div_reg})
			begin
				rem_next    = trial - {1'b0, div_reg};
				quo_next[0] = 1'b1;
			end
			else
				rem_next = trial;
			cnt_next = cnt_reg - 5'h01;
			if (cnt_reg == 5'h00)
			begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			cnt_reg  <= '0;
			rem_reg  <= '0;
			quo_reg  <= '0;
			div_reg  <= '0;
		end
		else
		begin
			busy_reg <= busy_next;
			done_reg <= done_next;
			cnt_reg  <= cnt_next;
			rem_reg  <= rem_next;
			quo_reg  <= quo_next;
			div_reg  <= div_next;
		end
	end

	assign busy_o = busy_reg;
	assign done_o = done_reg;
	assign quot_o = quo_reg;

endmodule

/* logic/rlr_ramp.sv */
// Notes on behaviour
// (RQ1) A full swing from 0 % to 100.0 % takes the ramp duration, 0.0 to 600.0 s, 10.0 s by default.
// (RQ2) Up and down movement use the same single step size.
// (RQ3) The preset value is signed within +/-500.0 %, 0.0 by default.
// (RQ4) Upward ramping stops at the upper limit, +/-500.0 %, default 100.0 %.
// (RQ5) Downward ramping stops at the lower limit, +/-500.0 %, default -100.0 %.
// (RQ6) While the preset input is high the output equals the preset at once, whatever raise and lower do.
// (RQ7) Raise alone ramps the output up at the common rate until the upper limit.
// (RQ8) Lower alone ramps the output down at the common rate until the lower limit.
// (RQ9) Neither or both directions hold the output, but an output above the upper limit ramps down to it.
// (RQ10) In the same hold, an output below the lower limit ramps up to it.
// (RQ11) When the upper limit is not above the lower limit the output equals the upper limit.
// (RQ12) The output is saved to a retention store and reloaded from it after start-up.
// (RQ13) The output is readable as a signed monitor that software cannot write.
// (RQ14) The output moves once per update tick by full scale over duration times tick rate, clamped at limits.
`timescale 1ns/1ps
module rlr_ramp
	import rlr_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 srst_i,
	// Control inputs from pins
	input  wire logic                 raise_i,
	input  wire logic                 lower_i,
	input  wire logic                 preset_load_i,
	// Retention store
	input  wire logic signed [VW-1:0] nv_value_i,
	input  wire logic                 nv_valid_i,
	output logic signed [VW-1:0]      nv_store_o,
	output logic                      nv_store_stb_o,
	// Register port
	input  wire logic [7:0]           addr_i,
	input  wire logic [31:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic [31:0]               rdata_o,
	// Reference output
	output logic signed [VW-1:0]      out_value_o
);

	rlr_state_t               state_reg, state_next;
	logic [RW-1:0]            ramp_reg, ramp_next;
	logic signed [VW-1:0]     preset_reg, preset_next;
	logic signed [VW-1:0]     upper_reg, upper_next;
	logic signed [VW-1:0]     lower_reg, lower_next;
	logic signed [AW-1:0]     acc_reg, acc_next;
	logic [AW-1:0]            step_reg, step_next;
	logic [31:0]              tick_cnt_reg, tick_cnt_next;
	logic                     tick_reg, tick_next;
	logic                     stb_reg, stb_next;
	logic [31:0]              rdata_reg, rdata_next;
	logic                     div_start;
	logic                     div_busy;
	logic                     div_done;
	logic [QW-1:0]            div_quot;
	logic [DW-1:0]            divisor;
	logic [CTL_N-1:0]         ctl_raw;
	logic [CTL_N-1:0]         ctl;
	logic signed [AW-1:0]     up_q, lo_q;
	logic signed [AW:0]       sum_up, sum_dn;
	logic                     hold;
	logic signed [31:0]       wval;
	logic signed [VW-1:0]     wlim;

	assign ctl_raw = {preset_load_i, lower_i, raise_i};

	// Three-stage capture per control pin; a change counts once stages two and three agree
	for (genvar g = 0; g < CTL_N; g++)
	begin : g_sync
		logic s1_reg, s2_reg, s3_reg, f_reg, f_next;
		always_comb
		begin
			f_next = (s2_reg == s3_reg) ? s3_reg : f_reg;
		end
		always_ff @(posedge clk_i)
		begin
			if (srst_i)
			begin
				s1_reg <= 1'b0;
				s2_reg <= 1'b0;
				s3_reg <= 1'b0;
				f_reg  <= 1'b0;
			end
			else
			begin
				s1_reg <= ctl_raw[g];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				f_reg  <= f_next;
			end
		end
		assign ctl[g] = f_reg;
	end

	// Divisor follows a ramp write at once, so the restarted division sees the new duration
	assign divisor = DW'(ramp_next) * DW'(TICKS_PER_DS); // RQ1 RQ14

	rlr_div u_div
	(
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.start_i    (div_start),
		.dividend_i (FULL_SCALE),
		.divisor_i  (divisor),
		.busy_o     (div_busy),
		.done_o     (div_done),
		.quot_o     (div_quot)
	);

	// Write data clamped to the +/-500.0 % span, so limits and preset always stay legal
	always_comb
	begin
		wval = signed'(wdata_i);
		if (wval > 32'(VAL_LIM))
			wlim = VAL_LIM; // RQ3 RQ4 RQ5
		else if (wval < -32'(VAL_LIM))
			wlim = -VAL_LIM;
		else
			wlim = wval[VW-1:0];
	end

	// Register writes and read data; the output register has no write path
	always_comb
	begin
		ramp_next   = ramp_reg;
		preset_next = preset_reg;
		upper_next  = upper_reg;
		lower_next  = lower_reg;
		rdata_next  = '0;
		div_start   = (state_reg == ST_CALC) && !div_busy && !div_done;
		if (wr_i)
		begin
			case (addr_i)
				A_RAMP:
				begin
					ramp_next = (wdata_i > 32'(RAMP_MAX)) ? RAMP_MAX : wdata_i[RW-1:0]; // RQ1
					div_start = 1'b1;
				end
				A_PRESET: preset_next = wlim; // RQ3
				A_UPPER:  upper_next  = wlim; // RQ4
				A_LOWER:  lower_next  = wlim; // RQ5
				default:  ; // RQ13
			endcase
		end
		if (rd_i)
		begin
			case (addr_i)
				A_RAMP:   rdata_next = 32'(ramp_reg);
				A_PRESET: rdata_next = 32'(preset_reg);
				A_UPPER:  rdata_next = 32'(upper_reg);
				A_LOWER:  rdata_next = 32'(lower_reg);
				A_OUTPUT: rdata_next = 32'(out_value_o); // RQ13
				A_STATUS: rdata_next = {25'h0, state_reg, div_busy, ctl};
				default:  rdata_next = '0;
			endcase
		end
	end

	// Free-running update tick
	always_comb
	begin
		tick_next     = 1'b0;
		tick_cnt_next = tick_cnt_reg + 32'h1;
		if (tick_cnt_reg >= 32'(TICK_LEN - 1))
		begin
			tick_cnt_next = '0;
			tick_next     = 1'b1; // RQ14
		end
	end

	// Ramp core: restore after start-up, then follow the control table each tick
	always_comb
	begin
		up_q       = {upper_reg, FB'(0)};
		lo_q       = {lower_reg, FB'(0)};
		sum_up     = {acc_reg[AW-1], acc_reg} + {1'b0, step_reg}; // RQ2
		sum_dn     = {acc_reg[AW-1], acc_reg} - {1'b0, step_reg}; // RQ2
		hold       = (ctl[CTL_RAISE] == ctl[CTL_LOWER]);
		state_next = state_reg;
		acc_next   = acc_reg;
		step_next  = step_reg;
		if (div_done)
			step_next = (ramp_reg == '0) ? STEP_MAX : AW'(div_quot); // RQ1
		case (state_reg)
			ST_RESTORE:
			begin
				if (nv_valid_i)
					acc_next = {nv_value_i, FB'(0)}; // RQ12
				state_next = ST_CALC;
			end
			ST_CALC:
			begin
				if (div_done)
					state_next = ST_RUN;
			end
			ST_RUN:
			begin
				if (upper_reg <= lower_reg)
					acc_next = up_q; // RQ11
				else if (ctl[CTL_PRESET])
					acc_next = {preset_reg, FB'(0)}; // RQ6
				else if (tick_reg)
				begin
					if (ctl[CTL_RAISE] && !ctl[CTL_LOWER] && acc_reg < up_q)
						acc_next = (sum_up > signed'({up_q[AW-1], up_q})) ? up_q : sum_up[AW-1:0]; // RQ7
					else if (ctl[CTL_LOWER] && !ctl[CTL_RAISE] && acc_reg > lo_q)
						acc_next = (sum_dn < signed'({lo_q[AW-1], lo_q})) ? lo_q : sum_dn[AW-1:0]; // RQ8
					else if (hold && acc_reg > up_q)
						acc_next = (sum_dn < signed'({up_q[AW-1], up_q})) ? up_q : sum_dn[AW-1:0]; // RQ9
					else if (hold && acc_reg < lo_q)
						acc_next = (sum_up > signed'({lo_q[AW-1], lo_q})) ? lo_q : sum_up[AW-1:0]; // RQ10
				end
			end
			default: state_next = ST_RESTORE;
		endcase
		// Each change of the whole-unit value is pushed to the retention store
		stb_next = (acc_next[AW-1:FB] != acc_reg[AW-1:FB]); // RQ12
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_reg    <= ST_RESTORE;
			ramp_reg     <= RAMP_RST;
			preset_reg   <= PRESET_RST;
			upper_reg    <= UPPER_RST;
			lower_reg    <= LOWER_RST;
			acc_reg      <= '0;
			step_reg     <= '0;
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
			stb_reg      <= 1'b0;
			rdata_reg    <= '0;
		end
		else
		begin
			state_reg    <= state_next;
			ramp_reg     <= ramp_next;
			preset_reg   <= preset_next;
			upper_reg    <= upper_next;
			lower_reg    <= lower_next;
			acc_reg      <= acc_next;
			step_reg     <= step_next;
			tick_cnt_reg <= tick_cnt_next;
			tick_reg     <= tick_next;
			stb_reg      <= stb_next;
			rdata_reg    <= rdata_next;
		end
	end

	assign out_value_o    = acc_reg[AW-1:FB];
	assign nv_store_o     = acc_reg[AW-1:FB];
	assign nv_store_stb_o = stb_reg;
	assign rdata_o        = rdata_reg;

	// Helper products for the step check
	logic [63:0] chk_lo, chk_hi;
	assign chk_lo = 64'(step_reg) * 64'(ramp_reg) * 64'(TICKS_PER_DS);
	assign chk_hi = 64'(step_reg + 32'h1) * 64'(ramp_reg) * 64'(TICKS_PER_DS);

	logic run_ok;
	assign run_ok = (state_reg == ST_RUN) && (upper_reg > lower_reg) && !wr_i;

	a_step_quot: assert property ( // RQ1
		@(posedge clk_i) disable iff (srst_i)
		div_done && ramp_reg != '0 && !wr_i |=> chk_lo <= 64'(FULL_SCALE) && chk_hi > 64'(FULL_SCALE))
	else $error("step does not match ramp duration");

	a_limit_force: assert property ( // RQ11
		@(posedge clk_i) disable iff (srst_i)
		state_reg == ST_RUN && upper_reg <= lower_reg |=> out_value_o == $past(upper_reg))
	else $error("output not forced to upper limit");

	a_preset_track: assert property ( // RQ6
		@(posedge clk_i) disable iff (srst_i)
		run_ok && ctl[CTL_PRESET] |=> out_value_o == $past(preset_reg))
	else $error("output does not track preset");

	a_raise_step: assert property ( // RQ7
		@(posedge clk_i) disable iff (srst_i)
		run_ok && !ctl[CTL_PRESET] && tick_reg && ctl[CTL_RAISE] && !ctl[CTL_LOWER]
		&& acc_reg < up_q |=> acc_reg > $past(acc_reg) && acc_reg <= $past(up_q))
	else $error("raise step wrong");

	a_lower_step: assert property ( // RQ8
		@(posedge clk_i) disable iff (srst_i)
		run_ok && !ctl[CTL_PRESET] && tick_reg && ctl[CTL_LOWER] && !ctl[CTL_RAISE]
		&& acc_reg > lo_q |=> acc_reg < $past(acc_reg) && acc_reg >= $past(lo_q))
	else $error("lower step wrong");

	a_hold_still: assert property ( // RQ9
		@(posedge clk_i) disable iff (srst_i)
		run_ok && !ctl[CTL_PRESET] && hold && acc_reg <= up_q && acc_reg >= lo_q
		&& !$changed(ctl) |=> $stable(acc_reg))
	else $error("output moved while held");

	a_pull_down: assert property ( // RQ9
		@(posedge clk_i) disable iff (srst_i)
		run_ok && !ctl[CTL_PRESET] && hold && tick_reg && acc_reg > up_q
		|=> acc_reg == ($past(sum_dn) < signed'({$past(up_q[AW-1]), $past(up_q)})
			? $past(up_q) : $past(acc_reg) - signed'($past(step_reg))))
	else $error("output above upper limit not pulled down");

	a_pull_up: assert property ( // RQ10
		@(posedge clk_i) disable iff (srst_i)
		run_ok && !ctl[CTL_PRESET] && hold && tick_reg && acc_reg < lo_q
		|=> acc_reg > $past(acc_reg) && acc_reg <= $past(lo_q))
	else $error("output below lower limit not pulled up");

	a_no_tick: assert property ( // RQ14
		@(posedge clk_i) disable iff (srst_i)
		run_ok && !ctl[CTL_PRESET] && !tick_reg |=> $stable(acc_reg))
	else $error("output moved without a tick");

	a_restore_load: assert property ( // RQ12
		@(posedge clk_i) disable iff (srst_i)
		state_reg == ST_RESTORE && nv_valid_i |=> out_value_o == $past(nv_value_i))
	else $error("retained value not restored");

	a_monitor_read: assert property ( // RQ13
		@(posedge clk_i) disable iff (srst_i)
		rd_i && addr_i == A_OUTPUT |=> rdata_o == 32'($past(out_value_o)))
	else $error("monitor read wrong");

	a_div_bound: assert property ( // RQ14
		@(posedge clk_i) disable iff (srst_i)
		div_start |-> ((##[1:26] div_start) or (##27 div_done)))
	else $error("step calculation late");

endmodule
